// ==== core/racr_defs.vh ====
// Register offsets, field positions, reset values and counts of the RTC block
`ifndef RACR_DEFS_VH
`define RACR_DEFS_VH

// Register offsets on the plain register port (word addresses)
`define RACR_ADDR_W 3
`define RACR_ADDR_CALIB 3'h0
`define RACR_ADDR_PAD 3'h1
`define RACR_ADDR_ALCFG 3'h2
`define RACR_ADDR_VALUE 3'h3
`define RACR_ADDR_ALVAL 3'h4

// Calibration and configuration fields
`define RACR_CC_EN 15
`define RACR_CC_UNLOCK 13
`define RACR_CC_SYNC 12
`define RACR_CC_HALF 11
`define RACR_CC_OE 10
`define RACR_CC_PTR_HI 9
`define RACR_CC_PTR_LO 8
`define RACR_CC_CAL_HI 7

// Pad output configuration fields
`define RACR_PAD_SEL_HI 2
`define RACR_PAD_SEL_LO 1

// Alarm configuration fields
`define RACR_AC_ON 15
`define RACR_AC_CHIME 14
`define RACR_AC_IVL_HI 13
`define RACR_AC_IVL_LO 10
`define RACR_AC_PTR_HI 9
`define RACR_AC_PTR_LO 8

// Implemented bits of each value layout
`define RACR_MASK_YEAR 16'h00FF
`define RACR_MASK_MD 16'h1F3F
`define RACR_MASK_WH 16'h073F
`define RACR_MASK_MS 16'h7F7F

// Reset values
`define RACR_RST_CFG 16'h0000
`define RACR_RST_YEAR 16'h0000
`define RACR_RST_MD 16'h0101
`define RACR_RST_WH 16'h0000
`define RACR_RST_MS 16'h0000

// Window pointer codes
`define RACR_PTR_MS 2'h0
`define RACR_PTR_WH 2'h1
`define RACR_PTR_MD 2'h2
`define RACR_PTR_YR 2'h3

// Pin source select codes
`define RACR_SEL_ALARM 2'h0
`define RACR_SEL_SEC 2'h1
`define RACR_SEL_REF 2'h2
`define RACR_SEL_RSVD 2'h3

// Alarm interval codes
`define RACR_IVL_HALF 4'h0
`define RACR_IVL_SEC 4'h1
`define RACR_IVL_10S 4'h2
`define RACR_IVL_MIN 4'h3
`define RACR_IVL_10M 4'h4
`define RACR_IVL_HOUR 4'h5
`define RACR_IVL_DAY 4'h6
`define RACR_IVL_WEEK 4'h7
`define RACR_IVL_MONTH 4'h8
`define RACR_IVL_YEAR 4'h9

// Counts: reference pulses per second, trim step shift, sync window
`define RACR_REF_HZ 32768
`define RACR_PRESC_W 17
`define RACR_TRIM_SHIFT 2
`define RACR_SYNC_WIN 6'h20
`define RACR_LAST_SEC 7'h59

`endif

// ==== core/racr_cal_step.v ====
// One-second BCD advance of the time and calendar values
`timescale 1ns/1ps
module racr_cal_step (
  input wire [15:0] ms_in,
  input wire [15:0] wh_in,
  input wire [15:0] md_in,
  input wire [15:0] yr_in,
  output reg [15:0] ms_out,
  output reg [15:0] wh_out,
  output reg [15:0] md_out,
  output reg [15:0] yr_out
);
`include "racr_defs.vh"

  // Returns {wrap, next} for a two-digit BCD count from first to top
  function [8:0] bcd_inc;
    input [7:0] v;
    input [7:0] top;
    input [7:0] first;
    begin
      if (v >= top)
        bcd_inc = {1'b1, first};
      else if (v[3:0] == 4'h9)
        bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  reg [8:0] s_n;
  reg [8:0] m_n;
  reg [8:0] h_n;
  reg [8:0] d_n;
  reg [8:0] mo_n;
  reg [8:0] y_n;
  reg [7:0] dim;
  reg leap;

  // Ripple from seconds up to the year; leap every fourth year in the century
  always @* begin
    leap = yr_in[4] ? (yr_in[3:0] == 4'h2 || yr_in[3:0] == 4'h6) :
      (yr_in[3:0] == 4'h0 || yr_in[3:0] == 4'h4 || yr_in[3:0] == 4'h8);
    case (md_in[12:8])
      5'h02: dim = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: dim = 8'h30;
      default: dim = 8'h31;
    endcase
    s_n = bcd_inc({1'b0, ms_in[6:0]}, 8'h59, 8'h00);
    m_n = bcd_inc({1'b0, ms_in[14:8]}, 8'h59, 8'h00);
    h_n = bcd_inc({2'b00, wh_in[5:0]}, 8'h23, 8'h00);
    d_n = bcd_inc({2'b00, md_in[5:0]}, dim, 8'h01);
    mo_n = bcd_inc({3'b000, md_in[12:8]}, 8'h12, 8'h01);
    y_n = bcd_inc(yr_in[7:0], 8'h99, 8'h00);
    ms_out = ms_in & `RACR_MASK_MS;
    wh_out = wh_in & `RACR_MASK_WH;
    md_out = md_in & `RACR_MASK_MD;
    yr_out = yr_in & `RACR_MASK_YEAR;
    ms_out[6:0] = s_n[6:0];
    if (s_n[8]) begin
      ms_out[14:8] = m_n[6:0];
      if (m_n[8]) begin
        wh_out[5:0] = h_n[5:0];
        if (h_n[8]) begin
          // Weekday is a plain 0..6 count
          wh_out[10:8] = (wh_in[10:8] >= 3'h6) ? 3'h0 : wh_in[10:8] + 3'h1;
          md_out[5:0] = d_n[5:0];
          if (d_n[8]) begin
            md_out[12:8] = mo_n[4:0];
            if (mo_n[8])
              yr_out[7:0] = y_n[7:0];
          end
        end
      end
    end
  end
endmodule

// ==== core/racr_regs.v ====
// Real-time clock, calendar and alarm with its register file
// How it works
// - Signed trim code, steps of 4 pulses per minute; 0x7F adds 508 pulses.
// - Code 0x80 subtracts 512 pulses per minute; zero gives no trim.
// - Code 0xFF subtracts 4 pulses; each code step is four pulses.
// - Calibration/config register is cleared by power-on reset only.
// - Module enable bit is written only while write unlock reads 1.
// - Half-second flag is read-only, cleared by a minutes/seconds write.
// - Pin source: 00 alarm pulse, 01 seconds clock, 10 reference clock.
// - Pin driven only while the output enable bit 10 is set.
// - Alarm enable self-clears after an event at count 00h without chime.
// - With chime the repeat count wraps 00h to FFh; otherwise holds 00h.
// - Interval codes 0000 half second up to 1001 yearly.
// - Yearly alarm on February 29 fires only once every four years.
// - Alarm window pointer steps down on each access, stops at 00.
// - Alarm pointer 00 min/sec, 01 weekday/hour, 10 month/day, 11 none.
// - Repeat count decrements on each alarm event, except one at 00h without chime.
// - Year is two BCD digits in the low byte; upper byte reads zero.
// - Year, month/day, weekday/hour writes need write unlock set.
// - Month tens bit 12, ones 11-8; day tens 5-4, ones 3-0.
// - Weekday bits 10-8, hour tens 5-4, hour ones 3-0.
// - Minute tens 14-12, ones 11-8; second tens 6-4, ones 3-0.
// - Value pointer steps down on each access, stops at 00; 11 selects year.
// - Every value window write is blocked while write unlock is clear.
// - Each alarm event raises a one-cycle interrupt request.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "racr_defs.vh"
module racr_regs #(
  parameter REF_HZ = `RACR_REF_HZ,
  parameter PW = `RACR_PRESC_W
) (
  input wire CLK_IN,
  input wire RST_B_IN,
  input wire SYS_RST_B_IN,
  input wire REF_TICK_IN,
  input wire REF_CLK_IN,
  input wire [`RACR_ADDR_W-1:0] ADDR_IN,
  input wire [15:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  output reg [15:0] RDATA_OUT,
  output reg RTCC_PIN_OUT,
  output reg RTCC_PIN_OE_OUT,
  output reg ALARM_IRQ_OUT
);

  localparam [PW-1:0] LAST = REF_HZ[PW-1:0] - 1'b1;
  localparam [PW-1:0] HALF = REF_HZ[PW:1];
  localparam [PW-1:0] HALF_PRE = REF_HZ[PW:1] - 1'b1;
  localparam [PW-1:0] SYNC_FROM = REF_HZ[PW-1:0] - `RACR_SYNC_WIN;

  // Calibration and configuration state
  reg module_enable_bit;
  reg value_write_unlock;
  reg clock_pin_output_enable;
  reg [1:0] value_window_pointer;
  reg [7:0] drift_trim;
  // Pad and alarm configuration
  reg [1:0] pin_source_select;
  reg alarm_on;
  reg chime_on;
  reg [3:0] alarm_interval_select;
  reg [1:0] alarm_window_pointer;
  reg [7:0] repeat_count;
  // Time values and alarm values
  reg [15:0] year_value;
  reg [15:0] month_day_value;
  reg [15:0] weekday_hour_value;
  reg [15:0] min_sec_value;
  reg [15:0] alarm_ms;
  reg [15:0] alarm_wh;
  reg [15:0] alarm_md;
  // Reference pulse prescaler, treated as two's complement
  reg [PW-1:0] presc;
  reg chk_half;
  reg chk_sec;
  reg alarm_pulse;

  wire [15:0] step_ms;
  wire [15:0] step_wh;
  wire [15:0] step_md;
  wire [15:0] step_yr;

  // Decoded accesses
  wire wr_cc = WR_IN && ADDR_IN == `RACR_ADDR_CALIB;
  wire wr_pad = WR_IN && ADDR_IN == `RACR_ADDR_PAD;
  wire wr_ac = WR_IN && ADDR_IN == `RACR_ADDR_ALCFG;
  wire wr_val = WR_IN && ADDR_IN == `RACR_ADDR_VALUE;
  wire wr_alv = WR_IN && ADDR_IN == `RACR_ADDR_ALVAL;
  wire val_acc = (WR_IN || RD_IN) && ADDR_IN == `RACR_ADDR_VALUE;
  wire alv_acc = (WR_IN || RD_IN) && ADDR_IN == `RACR_ADDR_ALVAL;
  // Locked writes to the value window are dropped whole
  wire val_ok = wr_val && value_write_unlock;
  wire ms_wr = val_ok && value_window_pointer == `RACR_PTR_MS;

  // Prescaler events
  wire presc_neg = presc[PW-1];
  wire ref_step = module_enable_bit && REF_TICK_IN && !ms_wr;
  wire sec_tick = ref_step && presc == LAST;
  wire half_tick = ref_step && presc == HALF_PRE;
  wire minute_end = min_sec_value[6:0] == `RACR_LAST_SEC;
  wire half_second_flag = !presc_neg && presc >= HALF;
  wire sync_flag = module_enable_bit && !presc_neg && presc >= SYNC_FROM;

  // Trim start value: code times four, sign extended
  wire [PW-1:0] trim_start =
    {{(PW-8-`RACR_TRIM_SHIFT){drift_trim[7]}}, drift_trim,
     {`RACR_TRIM_SHIFT{1'b0}}};

  racr_cal_step u_step (
    .ms_in(min_sec_value),
    .wh_in(weekday_hour_value),
    .md_in(month_day_value),
    .yr_in(year_value),
    .ms_out(step_ms),
    .wh_out(step_wh),
    .md_out(step_md),
    .yr_out(step_yr)
  );

  // Power-on-only register; the system reset leaves it alone
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      module_enable_bit <= 1'b0;
      value_write_unlock <= 1'b0;
      clock_pin_output_enable <= 1'b0;
      value_window_pointer <= `RACR_PTR_MS;
      drift_trim <= 8'h00;
    end else begin
      if (wr_cc) begin
        if (value_write_unlock)
          module_enable_bit <= WDATA_IN[`RACR_CC_EN];
        value_write_unlock <= WDATA_IN[`RACR_CC_UNLOCK];
        clock_pin_output_enable <= WDATA_IN[`RACR_CC_OE];
        drift_trim <= WDATA_IN[`RACR_CC_CAL_HI:0];
      end
      // Pointer steps down on reads and writes alike, even when locked
      if (wr_cc)
        value_window_pointer <=
          WDATA_IN[`RACR_CC_PTR_HI:`RACR_CC_PTR_LO];
      else if (val_acc && value_window_pointer != `RACR_PTR_MS)
        value_window_pointer <= value_window_pointer - 2'h1;
    end
  end

  // Prescaler: a positive trim starts the minute ahead, a negative one behind
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN)
      presc <= {PW{1'b0}};
    else if (ms_wr)
      presc <= {PW{1'b0}};
    else if (sec_tick)
      presc <= minute_end ? trim_start : {PW{1'b0}};
    else if (ref_step)
      presc <= presc + {{(PW-1){1'b0}}, 1'b1};
  end

  // Time values run through every reset but power-on; software write wins
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      year_value <= `RACR_RST_YEAR;
      month_day_value <= `RACR_RST_MD;
      weekday_hour_value <= `RACR_RST_WH;
      min_sec_value <= `RACR_RST_MS;
    end else if (val_ok) begin
      case (value_window_pointer)
        `RACR_PTR_MS: min_sec_value <= WDATA_IN & `RACR_MASK_MS;
        `RACR_PTR_WH: weekday_hour_value <= WDATA_IN & `RACR_MASK_WH;
        `RACR_PTR_MD: month_day_value <= WDATA_IN & `RACR_MASK_MD;
        default: year_value <= WDATA_IN & `RACR_MASK_YEAR;
      endcase
    end else if (sec_tick) begin
      year_value <= step_yr;
      month_day_value <= step_md;
      weekday_hour_value <= step_wh;
      min_sec_value <= step_ms;
    end
  end

  // Alarm value window; no write lock is applied here
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      alarm_ms <= `RACR_RST_MS;
      alarm_wh <= `RACR_RST_WH;
      alarm_md <= `RACR_RST_MD;
    end else if (wr_alv) begin
      case (alarm_window_pointer)
        `RACR_PTR_MS: alarm_ms <= WDATA_IN & `RACR_MASK_MS;
        `RACR_PTR_WH: alarm_wh <= WDATA_IN & `RACR_MASK_WH;
        `RACR_PTR_MD: alarm_md <= WDATA_IN & `RACR_MASK_MD;
        default: alarm_ms <= alarm_ms;
      endcase
    end
  end

  // Compare one cycle after a tick so the values have settled
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      chk_half <= 1'b0;
      chk_sec <= 1'b0;
    end else begin
      chk_half <= half_tick || sec_tick;
      chk_sec <= sec_tick;
    end
  end

  // Digit matches
  wire m_so = min_sec_value[3:0] == alarm_ms[3:0];
  wire m_s = min_sec_value[6:0] == alarm_ms[6:0];
  wire m_mo = min_sec_value[11:8] == alarm_ms[11:8];
  wire m_m = min_sec_value[14:8] == alarm_ms[14:8];
  wire m_h = weekday_hour_value[5:0] == alarm_wh[5:0];
  wire m_w = weekday_hour_value[10:8] == alarm_wh[10:8];
  wire m_d = month_day_value[5:0] == alarm_md[5:0];
  wire m_mon = month_day_value[12:8] == alarm_md[12:8];
  wire feb29 = alarm_md[12:8] == 5'h02 && alarm_md[5:0] == 6'h29;
  wire yr_leap = year_value[4] ?
    (year_value[3:0] == 4'h2 || year_value[3:0] == 4'h6) :
    (year_value[3:0] == 4'h0 || year_value[3:0] == 4'h4 ||
     year_value[3:0] == 4'h8);

  reg hit;

  // Interval decode; more digits must match as the interval grows
  always @* begin
    hit = 1'b0;
    case (alarm_interval_select)
      `RACR_IVL_HALF: hit = chk_half;
      `RACR_IVL_SEC: hit = chk_sec;
      `RACR_IVL_10S: hit = chk_sec && m_so;
      `RACR_IVL_MIN: hit = chk_sec && m_s;
      `RACR_IVL_10M: hit = chk_sec && m_s && m_mo;
      `RACR_IVL_HOUR: hit = chk_sec && m_s && m_m;
      `RACR_IVL_DAY: hit = chk_sec && m_s && m_m && m_h;
      `RACR_IVL_WEEK: hit = chk_sec && m_s && m_m && m_h && m_w;
      `RACR_IVL_MONTH: hit = chk_sec && m_s && m_m && m_h && m_d;
      `RACR_IVL_YEAR:
        hit = chk_sec && m_s && m_m && m_h && m_d && m_mon &&
          (!feb29 || yr_leap);
      default: hit = 1'b0;
    endcase
  end

  wire alarm_evt = alarm_on && hit;

  // Pad select and alarm configuration; system reset clears these too
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pin_source_select <= `RACR_SEL_ALARM;
      alarm_on <= 1'b0;
      chime_on <= 1'b0;
      alarm_interval_select <= `RACR_IVL_HALF;
      alarm_window_pointer <= `RACR_PTR_MS;
      repeat_count <= 8'h00;
    end else if (!SYS_RST_B_IN) begin
      pin_source_select <= `RACR_SEL_ALARM;
      alarm_on <= 1'b0;
      chime_on <= 1'b0;
      alarm_interval_select <= `RACR_IVL_HALF;
      alarm_window_pointer <= `RACR_PTR_MS;
      repeat_count <= 8'h00;
    end else begin
      if (wr_pad)
        pin_source_select <= WDATA_IN[`RACR_PAD_SEL_HI:`RACR_PAD_SEL_LO];
      // A software write in the event cycle takes precedence
      if (wr_ac) begin
        alarm_on <= WDATA_IN[`RACR_AC_ON];
        chime_on <= WDATA_IN[`RACR_AC_CHIME];
        alarm_interval_select <=
          WDATA_IN[`RACR_AC_IVL_HI:`RACR_AC_IVL_LO];
        repeat_count <= WDATA_IN[7:0];
      end else if (alarm_evt) begin
        repeat_count <= repeat_count - 8'h01;
        if (repeat_count == 8'h00) begin
          if (chime_on)
            repeat_count <= 8'hFF;
          else begin
            repeat_count <= 8'h00;
            alarm_on <= 1'b0;
          end
        end
      end
      if (wr_ac)
        alarm_window_pointer <=
          WDATA_IN[`RACR_AC_PTR_HI:`RACR_AC_PTR_LO];
      else if (alv_acc && alarm_window_pointer != `RACR_PTR_MS)
        alarm_window_pointer <= alarm_window_pointer - 2'h1;
    end
  end

  // Interrupt pulse and half-rate alarm pulse
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ALARM_IRQ_OUT <= 1'b0;
      alarm_pulse <= 1'b0;
    end else begin
      ALARM_IRQ_OUT <= alarm_evt;
      if (alarm_evt)
        alarm_pulse <= !alarm_pulse;
    end
  end

  reg next_pin;

  // Pin source; the reference level is passed through one flop
  always @* begin
    case (pin_source_select)
      `RACR_SEL_ALARM: next_pin = alarm_pulse;
      `RACR_SEL_SEC: next_pin = half_second_flag;
      `RACR_SEL_REF: next_pin = REF_CLK_IN;
      default: next_pin = 1'b0;
    endcase
  end

  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      RTCC_PIN_OUT <= 1'b0;
      RTCC_PIN_OE_OUT <= 1'b0;
    end else begin
      RTCC_PIN_OUT <= clock_pin_output_enable && next_pin;
      RTCC_PIN_OE_OUT <= clock_pin_output_enable &&
        pin_source_select != `RACR_SEL_RSVD;
    end
  end

  reg [15:0] next_rdata;

  // Read mux; unmapped offsets and unimplemented bits read zero
  always @* begin
    next_rdata = 16'h0000;
    case (ADDR_IN)
      `RACR_ADDR_CALIB:
        next_rdata = {module_enable_bit, 1'b0, value_write_unlock,
          sync_flag, half_second_flag, clock_pin_output_enable,
          value_window_pointer, drift_trim};
      `RACR_ADDR_PAD:
        next_rdata = {13'h0000, pin_source_select, 1'b0};
      `RACR_ADDR_ALCFG:
        next_rdata = {alarm_on, chime_on, alarm_interval_select,
          alarm_window_pointer, repeat_count};
      `RACR_ADDR_VALUE:
        case (value_window_pointer)
          `RACR_PTR_MS: next_rdata = min_sec_value;
          `RACR_PTR_WH: next_rdata = weekday_hour_value;
          `RACR_PTR_MD: next_rdata = month_day_value;
          default: next_rdata = year_value;
        endcase
      `RACR_ADDR_ALVAL:
        case (alarm_window_pointer)
          `RACR_PTR_MS: next_rdata = alarm_ms;
          `RACR_PTR_WH: next_rdata = alarm_wh;
          `RACR_PTR_MD: next_rdata = alarm_md;
          default: next_rdata = 16'h0000;
        endcase
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN)
      RDATA_OUT <= 16'h0000;
    else
      RDATA_OUT <= RD_IN ? next_rdata : 16'h0000;
  end
endmodule

// ==== tb/racr_regs_assertions.sv ====
// Port-level assertions of the RTC register block
`timescale 1ns/1ps
`include "racr_defs.vh"
module racr_regs_assertions (
  input wire CLK_IN,
  input wire RST_B_IN,
  input wire SYS_RST_B_IN,
  input wire REF_CLK_IN,
  input wire [`RACR_ADDR_W-1:0] ADDR_IN,
  input wire [15:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  input wire [15:0] RDATA_OUT,
  input wire RTCC_PIN_OUT,
  input wire RTCC_PIN_OE_OUT,
  input wire ALARM_IRQ_OUT
);
  reg en;
  reg unl;
  reg oe;
  reg [7:0] trim;
  reg [1:0] sel;
  // Shadows of written fields; calib ignores the system reset on purpose
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      en <= 1'b0;
      unl <= 1'b0;
      oe <= 1'b0;
      trim <= 8'h00;
      sel <= 2'h0;
    end else begin
      if (WR_IN && ADDR_IN == `RACR_ADDR_CALIB) begin
        en <= unl ? WDATA_IN[15] : en;
        unl <= WDATA_IN[13];
        oe <= WDATA_IN[10];
        trim <= WDATA_IN[7:0];
      end
      if (!SYS_RST_B_IN) begin
        sel <= 2'h0;
      end else if (WR_IN && ADDR_IN == `RACR_ADDR_PAD) begin
        sel <= WDATA_IN[2:1];
      end
    end
  end
  default clocking dcb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  sequence s_read(a);
    RD_IN && ADDR_IN == a;
  endsequence
  sequence s_pulse;
    ALARM_IRQ_OUT ##1 !ALARM_IRQ_OUT [*8];
  endsequence
  a_rdata_idle: assert property (!RD_IN |=> RDATA_OUT == 16'h0000)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (RD_IN && ADDR_IN > `RACR_ADDR_ALVAL
    |=> RDATA_OUT == 16'h0000) else $error("unmapped read not zero");
  a_cal_fields: assert property (s_read(`RACR_ADDR_CALIB) |=>
    {RDATA_OUT[15:13], RDATA_OUT[10], RDATA_OUT[7:0]} ==
    {en, 1'b0, unl, oe, trim}) else $error("calib fields wrong");
  a_pad_fields: assert property (s_read(`RACR_ADDR_PAD) |=>
    RDATA_OUT == {13'h0000, sel, 1'b0}) else $error("pad read wrong");
  a_pin_off: assert property (!oe |=> !RTCC_PIN_OE_OUT && !RTCC_PIN_OUT)
    else $error("pin active while output disabled");
  a_oe_on: assert property (oe && sel != `RACR_SEL_RSVD
    |=> RTCC_PIN_OE_OUT) else $error("pin not driven while enabled");
  a_pin_rsvd: assert property (sel == `RACR_SEL_RSVD
    |=> !RTCC_PIN_OE_OUT && !RTCC_PIN_OUT) else $error("reserved pin active");
  a_pin_ref: assert property (oe && sel == `RACR_SEL_REF
    |=> RTCC_PIN_OUT == $past(REF_CLK_IN)) else $error("pin not ref clock");
  a_irq_pulse: assert property ($rose(ALARM_IRQ_OUT) |-> s_pulse)
    else $error("alarm request not a single pulse");
endmodule

// ==== tb/racr_regs_tb.sv ====
// Self-checking bench of the RTC register block
`timescale 1ns/1ps
`include "racr_defs.vh"
module racr_regs_tb;
  localparam int HZ = 1024;
  localparam logic [2:0] CAL = `RACR_ADDR_CALIB;
  localparam logic [2:0] PAD = `RACR_ADDR_PAD;
  localparam logic [2:0] ALC = `RACR_ADDR_ALCFG;
  localparam logic [2:0] VAL = `RACR_ADDR_VALUE;
  localparam logic [2:0] ALV = `RACR_ADDR_ALVAL;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sys_b = 1'b1;
  logic tick = 1'b0;
  logic ref_clk = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  wire [15:0] rdata;
  wire pin, pin_oe, irq;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int irq_cnt = 0;
  int irq_base = 0;
  int i;
  logic [15:0] v;
  logic [15:0] q[$];
  logic [7:0] trims[4] = '{8'h7F, 8'h80, 8'hFF, 8'h00};
  logic [3:0] codes[4] = '{4'h0, 4'h1, 4'hA, 4'hC};
  int cnts[4] = '{4, 2, 0, 0};
  racr_regs #(.REF_HZ(HZ), .PW(17)) i_dut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .SYS_RST_B_IN(sys_b),
    .REF_TICK_IN(tick), .REF_CLK_IN(ref_clk), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .RTCC_PIN_OUT(pin), .RTCC_PIN_OE_OUT(pin_oe), .ALARM_IRQ_OUT(irq));
  always #50 clk = ~clk;
  // Random reference level, alarm pulse counting and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ref_clk <= 1'($urandom);
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cyc == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rchk(input string n, input logic [2:0] a,
                      input logic [15:0] m, e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, rdata & m, e);
  endtask
  // Reference pulses held back otherwise, so counts are exact
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
    end
    @(posedge clk);
    tick <= 1'b0;
  endtask
  function automatic logic [15:0] bcd(input int n);
    return 16'(((n / 10) << 4) | (n % 10));
  endfunction
  function automatic logic [15:0] msk(input int k);
    case (k)
      0: return `RACR_MASK_MS;
      1: return `RACR_MASK_WH;
      2: return `RACR_MASK_MD;
      default: return `RACR_MASK_YEAR;
    endcase
  endfunction
  // Valid BCD contents, with every unimplemented bit set as bait
  function automatic logic [15:0] mk(input int k);
    case (k)
      0: return (bcd($urandom % 60) << 8) | bcd($urandom % 60) | 16'h8080;
      1: return (16'($urandom % 7) << 8) | bcd($urandom % 24) | 16'hF8C0;
      2: return (bcd(1 + $urandom % 12) << 8) | bcd(1 + $urandom % 28)
                | 16'hE0C0;
      default: return bcd($urandom % 100) | 16'hFF00;
    endcase
  endfunction
  function automatic int rep_after(input int r, input int n, input bit ch);
    for (int k = 0; k < n; k++) begin
      r = (r == 0) ? (ch ? 255 : 0) : r - 1;
    end
    return r;
  endfunction
  // Fill a window from pointer 3 down, then read it back the same way
  task automatic window(input logic [2:0] cfg, win, input logic [15:0] cv);
    int k;
    logic [15:0] w;
    q = {};
    wr_reg(cfg, cv);
    for (k = 3; k >= 0; k--) begin
      w = mk(k);
      q.push_back((win == ALV && k == 3) ? 16'h0000 : w & msk(k));
      wr_reg(win, w);
    end
    wr_reg(cfg, cv);
    for (k = 3; k >= 0; k--) begin
      rchk("window", win, 16'hFFFF, q.pop_front());
    end
  endtask
  initial begin
    i = $urandom(32'h2B9EDB51);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) rchk("reset", 3'(i), 16'hFFFF, 16'h0000);
    wr_reg(CAL, 16'h0300);
    wr_reg(VAL, 16'h0099);
    wr_reg(CAL, 16'h0300);
    rchk("locked year", VAL, 16'hFFFF, 16'h0000);
    wr_reg(CAL, 16'hA000);
    rchk("unlock only", CAL, 16'hE7FF, 16'h2000);
    window(CAL, VAL, 16'hA300);
    rchk("value ptr", CAL, 16'hE7FF, 16'hA000);
    window(ALC, ALV, 16'h0300);
    rchk("alarm ptr", ALC, 16'hFFFF, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wr_reg(CAL, {8'hA0, trims[i]});
      wr_reg(VAL, 16'h0059);
      ticks(HZ);
      ticks(HZ - 4 * $signed(trims[i]) - 1);
      rchk("trim end", VAL, 16'hFFFF, 16'h0100);
      ticks(1);
      rchk("trim next", VAL, 16'hFFFF, 16'h0101);
    end
    wr_reg(VAL, 16'h0000);
    ticks(HZ / 2 + 10);
    rchk("half set", CAL, 16'h0800, 16'h0800);
    wr_reg(VAL, 16'h0000);
    rchk("half clear", CAL, 16'h0800, 16'h0000);
    wr_reg(CAL, 16'hA400);
    for (i = 0; i < 4; i++) begin
      wr_reg(ALC, {2'h3, codes[i], 2'h0, 8'h01});
      wr_reg(VAL, 16'h0000);
      irq_base = irq_cnt;
      ticks(2100);
      repeat (4) @(posedge clk);
      chk("irq count", 16'(irq_cnt - irq_base), 16'(cnts[i]));
      v = {2'h3, codes[i], 2'h0, 8'(rep_after(1, cnts[i], 1'b1))};
      rchk("repeat", ALC, 16'hFFFF, v);
    end
    wr_reg(ALC, 16'h8002);
    wr_reg(VAL, 16'h0000);
    irq_base = irq_cnt;
    ticks(2100);
    repeat (4) @(posedge clk);
    chk("one shot", 16'(irq_cnt - irq_base), 16'd3);
    rchk("alarm off", ALC, 16'hFFFF, 16'h0000);
    // Yearly alarm on Feb 29: year 4 is a leap year and fires, year 1 not
    for (i = 0; i < 2; i++) begin
      wr_reg(ALC, 16'hA600);
      wr_reg(ALV, 16'h0229);
      wr_reg(ALV, 16'h0000);
      wr_reg(ALV, 16'h0001);
      wr_reg(CAL, 16'hA700);
      wr_reg(VAL, 16'(4 - 3 * i));
      wr_reg(VAL, 16'h0229);
      wr_reg(VAL, 16'h0000);
      wr_reg(VAL, 16'h0000);
      irq_base = irq_cnt;
      ticks(HZ);
      repeat (4) @(posedge clk);
      chk("feb 29", 16'(irq_cnt - irq_base), 16'(1 - i));
    end
    wr_reg(PAD, 16'h0004);
    repeat (20) @(posedge clk);
    wr_reg(PAD, 16'hFFFF);
    rchk("pad bits", PAD, 16'hFFFF, 16'h0006);
    repeat (3) @(posedge clk);
    chk("rsvd pin", 16'(pin_oe), 16'h0000);
    wr_reg(PAD, 16'h0002);
    repeat (5) @(posedge clk);
    wr_reg(CAL, 16'hA000);
    repeat (3) @(posedge clk);
    chk("pin off", 16'(pin_oe), 16'h0000);
    wr_reg(CAL, 16'hA47F);
    wr_reg(PAD, 16'h0004);
    wr_reg(ALC, 16'hC5AB);
    @(posedge clk);
    sys_b <= 1'b0;
    @(posedge clk);
    sys_b <= 1'b1;
    rchk("calib kept", CAL, 16'hE7FF, 16'hA47F);
    rchk("pad cleared", PAD, 16'hFFFF, 16'h0000);
    rchk("alarm cleared", ALC, 16'hFFFF, 16'h0000);
    report_and_stop();
  end
endmodule
bind racr_regs racr_regs_assertions i_chk (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .SYS_RST_B_IN(SYS_RST_B_IN),
  .REF_CLK_IN(REF_CLK_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .RTCC_PIN_OUT(RTCC_PIN_OUT), .RTCC_PIN_OE_OUT(RTCC_PIN_OE_OUT),
  .ALARM_IRQ_OUT(ALARM_IRQ_OUT));
